// [evt_core.sv]
// Exception classifier, priority arbiter and vector fetch sequencer
`timescale 1ns/1ps
module evt_core
   import evt_pkg::*;
(
   input  wire logic                     mclk,
   input  wire logic                     nrst,
   input  wire logic                     nmi_req,
   input  wire logic                     entry_error,
   input  wire logic                     mem_fault,
   input  wire logic                     bus_err_precise,
   input  wire logic                     bus_err_imprecise,
   input  wire logic                     undef_instr,
   input  wire logic                     illegal_unaligned,
   input  wire logic                     invalid_state,
   input  wire logic                     return_error,
   input  wire logic                     unaligned_access,
   input  wire logic                     div_by_zero,
   input  wire logic                     trap_unaligned_en,
   input  wire logic                     trap_div_zero_en,
   input  wire logic                     supervisor_call_instruction,
   input  wire logic                     pendable_service_request,
   input  wire logic                     systick_zero,
   input  wire logic                     systick_sw_req,
   input  wire logic [NUM_IRQ-1:0]       irq_line,
   input  wire logic [NUM_IRQ-1:0]       irq_sw_req,
   input  wire logic                     mem_en,
   input  wire logic                     bus_en,
   input  wire logic                     usage_en,
   input  wire logic                     svc_en,
   input  wire logic                     pendable_service_request_en,
   input  wire logic                     systick_en,
   input  wire logic [NUM_IRQ-1:0]       irq_en,
   input  wire logic [PRIO_W-1:0]        prio_mem,
   input  wire logic [PRIO_W-1:0]        prio_bus,
   input  wire logic [PRIO_W-1:0]        prio_usage,
   input  wire logic [PRIO_W-1:0]        prio_svc,
   input  wire logic [PRIO_W-1:0]        prio_pendable_service_request,
   input  wire logic [PRIO_W-1:0]        prio_systick,
   input  wire logic [NUM_IRQ*PRIO_W-1:0] prio_irq,
   input  wire logic                     vbr_write,
   input  wire logic [31:0]              vbr_wdata,
   input  wire logic                     vec_ack,
   input  wire logic                     exc_return,
   output logic                          vec_fetch_valid,
   output logic [31:0]                   vec_fetch_addr,
   output logic [NUM_W-1:0]              vec_fetch_num,
   output logic                          vec_load_sp,
   output logic                          entry_sync,
   output logic                          entry_async_slip,
   output logic                          entry_fault_handler,
   output logic [NUM_W-1:0]              active_exception_number_status,
   output logic [31:0]                   vector_base_register,
   output logic [NUM_EXC-1:0]            pending_status
);

   //---------------------------------------------------------------------------
   // Event classification
   //---------------------------------------------------------------------------
   logic                  usage_event;
   logic                  bus_event;
   logic                  hard_set;
   logic                  bus_precise;
   logic [NUM_EXC-1:0]    pend_set;
   logic [NUM_EXC-1:0]    pend_clr;
   logic [NUM_EXC-1:0]    enabled;
   logic [NUM_EXC-1:0]    eligible;
   logic [RANK_W-1:0]     rank [NUM_EXC];
   evt_state_e            state;
   evt_state_e            next_state;
   logic [RANK_W-1:0]     active_rank;

   assign usage_event = undef_instr | illegal_unaligned | invalid_state
                      | return_error
                      | (unaligned_access & trap_unaligned_en)
                      | (div_by_zero & trap_div_zero_en);
   assign bus_event   = bus_err_precise | bus_err_imprecise;

   // A fault with its handler switched off has no other place to go
   assign hard_set = entry_error
                   | (mem_fault & ~mem_en)
                   | (bus_event & ~bus_en)
                   | (usage_event & ~usage_en)
                   | (supervisor_call_instruction & ~svc_en);

   //---------------------------------------------------------------------------
   // Pending set vector, indexed by exception number
   //---------------------------------------------------------------------------
   assign pend_set[EXC_THREAD]  = 1'b0;
   assign pend_set[EXC_RESET]   = 1'b0;
   assign pend_set[EXC_NMI]     = nmi_req;
   assign pend_set[EXC_HARD]    = hard_set;
   assign pend_set[EXC_MEM]     = mem_fault & mem_en;
   assign pend_set[EXC_BUS]     = bus_event & bus_en;
   assign pend_set[EXC_USAGE]   = usage_event & usage_en;
   assign pend_set[10:7]        = '0;
   assign pend_set[EXC_SVC]     = supervisor_call_instruction & svc_en;
   assign pend_set[13:12]       = '0;
   assign pend_set[EXC_PENDABLE_SERVICE_REQUEST]  = pendable_service_request;
   assign pend_set[EXC_SYSTICK] = systick_zero | systick_sw_req;
   assign pend_set[NUM_EXC-1:EXC_IRQ0] = irq_line | irq_sw_req;

   //---------------------------------------------------------------------------
   // Enables and ranks
   //---------------------------------------------------------------------------
   assign enabled[EXC_THREAD]  = 1'b0;
   assign enabled[EXC_RESET]   = 1'b0;
   assign enabled[EXC_NMI]     = 1'b1;
   assign enabled[EXC_HARD]    = 1'b1;
   assign enabled[EXC_MEM]     = mem_en;
   assign enabled[EXC_BUS]     = bus_en;
   assign enabled[EXC_USAGE]   = usage_en;
   assign enabled[10:7]        = '0;
   assign enabled[EXC_SVC]     = svc_en;
   assign enabled[13:12]       = '0;
   assign enabled[EXC_PENDABLE_SERVICE_REQUEST]  = pendable_service_request_en;
   assign enabled[EXC_SYSTICK] = systick_en;
   assign enabled[NUM_EXC-1:EXC_IRQ0] = irq_en;

   // Configurable values are four bits wide, so they can never reach a fixed rank
   assign rank[EXC_THREAD]  = RANK_THREAD;
   assign rank[EXC_RESET]   = RANK_RESET;
   assign rank[EXC_NMI]     = RANK_NMI;
   assign rank[EXC_HARD]    = RANK_HARD;
   assign rank[EXC_MEM]     = RANK_W'({1'b0, prio_mem}) + RANK_OFFSET;
   assign rank[EXC_BUS]     = RANK_W'({1'b0, prio_bus}) + RANK_OFFSET;
   assign rank[EXC_USAGE]   = RANK_W'({1'b0, prio_usage}) + RANK_OFFSET;
   assign rank[7]           = RANK_THREAD;
   assign rank[8]           = RANK_THREAD;
   assign rank[9]           = RANK_THREAD;
   assign rank[10]          = RANK_THREAD;
   assign rank[EXC_SVC]     = RANK_W'({1'b0, prio_svc}) + RANK_OFFSET;
   assign rank[12]          = RANK_THREAD;
   assign rank[13]          = RANK_THREAD;
   assign rank[EXC_PENDABLE_SERVICE_REQUEST]  = RANK_W'({1'b0, prio_pendable_service_request}) + RANK_OFFSET;
   assign rank[EXC_SYSTICK] = RANK_W'({1'b0, prio_systick}) + RANK_OFFSET;

   //---------------------------------------------------------------------------
   // Per-number pending flags
   //---------------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < NUM_IRQ; g++) begin : g_irq_rank
         assign rank[EXC_IRQ0+g] = RANK_W'({1'b0, prio_irq[g*PRIO_W +: PRIO_W]})
                                 + RANK_OFFSET;
      end
      for (g = 0; g < NUM_EXC; g++) begin : g_pend
         evt_pend_bit u_pend (
            .mclk (mclk),
            .nrst (nrst),
            .set  (pend_set[g]),
            .clr  (pend_clr[g]),
            .pend (pending_status[g])
         );
         assign pend_clr[g] = vec_ack & vec_fetch_valid & (state == EVT_ST_RUN)
                            & (vec_fetch_num == NUM_W'(g));
         // Only strictly higher priority than the running handler may enter
         assign eligible[g] = pending_status[g] & enabled[g]
                            & (rank[g] < active_rank);
      end
   endgenerate

   //---------------------------------------------------------------------------
   // Arbitration
   //---------------------------------------------------------------------------
   logic              win_found;
   logic [NUM_W-1:0]  win_num;
   logic [RANK_W-1:0] win_rank;

   // Ascending scan with strict compare keeps the lowest number on a tie
   always_comb begin
      win_found = 1'b0;
      win_num   = EXC_THREAD;
      win_rank  = RANK_THREAD;
      for (int i = 0; i < NUM_EXC; i++) begin
         if (eligible[i] && (rank[i] < win_rank)) begin
            win_found = 1'b1;
            win_num   = NUM_W'(i);
            win_rank  = rank[i];
         end
      end
   end

   logic win_sync;
   logic win_fault;
   logic [31:0] win_addr;

   assign win_sync  = (win_num == EXC_MEM) | (win_num == EXC_USAGE)
                    | (win_num == EXC_HARD) | (win_num == EXC_SVC)
                    | ((win_num == EXC_BUS) & bus_precise);
   assign win_fault = (win_num == EXC_HARD) | (win_num == EXC_MEM)
                    | (win_num == EXC_BUS) | (win_num == EXC_USAGE);
   // Interrupt vectors land from 0x40 upward in four-byte steps
   assign win_addr  = vector_base_register
                    + {24'h00_0000, win_num, 2'b00};

   //---------------------------------------------------------------------------
   // Vector base register
   //---------------------------------------------------------------------------
   logic vbr_ok;

   // Out-of-range or misaligned values are dropped rather than truncated
   assign vbr_ok = vbr_write & (vbr_wdata >= VBR_MIN) & (vbr_wdata <= VBR_MAX)
                 & ((vbr_wdata & VBR_ALIGN) == '0);

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         vector_base_register <= VBR_RESET;
      end else if (vbr_ok) begin
         vector_base_register <= vbr_wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         bus_precise <= 1'b0;
      end else if (bus_err_precise) begin
         bus_precise <= 1'b1;
      end else if (bus_err_imprecise | pend_clr[EXC_BUS]) begin
         bus_precise <= 1'b0;
      end
   end

   //---------------------------------------------------------------------------
   // Reset and dispatch sequencer
   //---------------------------------------------------------------------------
   logic took;

   assign took = vec_ack & vec_fetch_valid;

   always_comb begin
      next_state = state;
      case (state)
         EVT_ST_SP:  if (took) next_state = EVT_ST_PC;
         EVT_ST_PC:  if (took) next_state = EVT_ST_RUN;
         EVT_ST_RUN: next_state = EVT_ST_RUN;
         default:    next_state = EVT_ST_SP;
      endcase
   end

   logic              next_valid;
   logic [31:0]       next_addr;
   logic [NUM_W-1:0]  next_num;
   logic              next_sp;
   logic              next_sync;
   logic              next_fault;

   // The ack cycle drops valid so a cleared flag is never offered twice
   assign next_valid = ~took & ((next_state != EVT_ST_RUN) | win_found);
   assign next_sp    = (next_state == EVT_ST_SP);
   assign next_addr  = (next_state == EVT_ST_SP) ? vector_base_register + VEC_SP_OFFSET :
                       (next_state == EVT_ST_PC) ?
                          vector_base_register + {24'h00_0000, EXC_RESET, 2'b00} :
                          win_addr;
   assign next_num   = (next_state == EVT_ST_RUN) ? win_num :
                       (next_state == EVT_ST_PC) ? EXC_RESET : EXC_THREAD;
   assign next_sync  = (next_state == EVT_ST_RUN) & win_sync;
   assign next_fault = (next_state == EVT_ST_RUN) & win_fault;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         state <= EVT_ST_SP;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         vec_fetch_valid     <= 1'b0;
         vec_fetch_addr      <= VBR_RESET;
         vec_fetch_num       <= EXC_THREAD;
         vec_load_sp         <= 1'b0;
         entry_sync          <= 1'b0;
         entry_async_slip    <= 1'b0;
         entry_fault_handler <= 1'b0;
      end else begin
         vec_fetch_valid     <= next_valid;
         vec_fetch_addr      <= next_addr;
         vec_fetch_num       <= next_num;
         vec_load_sp         <= next_sp;
         entry_sync          <= next_sync;
         // Reset never slips; other asynchronous entries may retire one more
         entry_async_slip    <= (next_state == EVT_ST_RUN) & ~win_sync;
         entry_fault_handler <= next_fault;
      end
   end

   //---------------------------------------------------------------------------
   // Active exception tracking
   //---------------------------------------------------------------------------
   // Single level only: a return drops to thread unless an entry is taken in the same cycle, nesting is the core's job
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         active_exception_number_status <= EXC_THREAD;
         active_rank                    <= RANK_RESET;
      end else if (took && (state == EVT_ST_PC)) begin
         active_exception_number_status <= EXC_THREAD;
         active_rank                    <= RANK_THREAD;
      end else if (took && (state == EVT_ST_RUN)) begin
         active_exception_number_status <= vec_fetch_num;
         active_rank                    <= rank[vec_fetch_num];
      end else if (exc_return && (state == EVT_ST_RUN)) begin
         active_exception_number_status <= EXC_THREAD;
         active_rank                    <= RANK_THREAD;
      end
   end

endmodule : evt_core

// [evt_pkg.sv]
// Constants, encodings and ranks shared by the exception type and vector table block
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
package evt_pkg;

   localparam int          NUM_IRQ       = 33;
   localparam int          NUM_EXC       = 16 + NUM_IRQ;
   localparam int          NUM_W         = 6;
   localparam int          PRIO_W        = 4;
   localparam int          RANK_W        = 5;

   localparam logic [5:0]  EXC_THREAD    = 6'h00;
   localparam logic [5:0]  EXC_RESET     = 6'h01;
   localparam logic [5:0]  EXC_NMI       = 6'h02;
   localparam logic [5:0]  EXC_HARD      = 6'h03;
   localparam logic [5:0]  EXC_MEM       = 6'h04;
   localparam logic [5:0]  EXC_BUS       = 6'h05;
   localparam logic [5:0]  EXC_USAGE     = 6'h06;
   localparam logic [5:0]  EXC_SVC       = 6'h0b;
   localparam logic [5:0]  EXC_PENDABLE_SERVICE_REQUEST    = 6'h0e;
   localparam logic [5:0]  EXC_SYSTICK   = 6'h0f;
   localparam int          EXC_IRQ0      = 16;

   // Rank is priority plus three, so -3 maps to 0 and unsigned compare works
   localparam logic [4:0]  RANK_RESET    = 5'h00;
   localparam logic [4:0]  RANK_NMI      = 5'h01;
   localparam logic [4:0]  RANK_HARD     = 5'h02;
   localparam logic [4:0]  RANK_OFFSET   = 5'h03;
   localparam logic [4:0]  RANK_THREAD   = 5'h1f;

   localparam logic [31:0] VEC_SP_OFFSET = 32'h0000_0000;
   localparam logic [31:0] VEC_IRQ_BASE  = 32'h0000_0040;
   localparam int          VEC_SHIFT     = 2;
   localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
   localparam logic [31:0] VBR_MIN       = 32'h0000_0080;
   localparam logic [31:0] VBR_MAX       = 32'h03ff_ff80;
   localparam logic [31:0] VBR_ALIGN     = 32'h0000_007f;

   typedef enum logic [1:0] {
      EVT_ST_SP  = 2'b00,
      EVT_ST_PC  = 2'b01,
      EVT_ST_RUN = 2'b11
   } evt_state_e;

endpackage : evt_pkg

// [evt_pend_bit.sv]
// Sticky pending flag for one exception number
`timescale 1ns/1ps
module evt_pend_bit (
   input  wire logic mclk,
   input  wire logic nrst,
   input  wire logic set,
   input  wire logic clr,
   output logic      pend
);
   // A new request in the clearing cycle is kept pending
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pend <= 1'b0;
      end else if (set) begin
         pend <= 1'b1;
      end else if (clr) begin
         pend <= 1'b0;
      end
   end
endmodule : evt_pend_bit

// [evt_core_checker.sv]
// Concurrent checks on the vector fetch and status ports of evt_core
`timescale 1ns/1ps
module evt_core_checker
   import evt_pkg::*;
(
   input wire logic               mclk,
   input wire logic               nrst,
   input wire logic [NUM_IRQ-1:0] irq_line,
   input wire logic               vbr_write,
   input wire logic [31:0]        vbr_wdata,
   input wire logic               vec_ack,
   input wire logic               vec_fetch_valid,
   input wire logic [31:0]        vec_fetch_addr,
   input wire logic [NUM_W-1:0]   vec_fetch_num,
   input wire logic               vec_load_sp,
   input wire logic               entry_sync,
   input wire logic               entry_async_slip,
   input wire logic               entry_fault_handler,
   input wire logic [NUM_W-1:0]   active_exception_number_status,
   input wire logic [31:0]        vector_base_register,
   input wire logic [NUM_EXC-1:0] pending_status
);
   wire [31:0] exp_addr = vector_base_register + {24'h000000, vec_fetch_num, 2'b00};
   wire        vbr_ok   = vbr_wdata >= VBR_MIN && vbr_wdata <= VBR_MAX &&
                          (vbr_wdata & VBR_ALIGN) == 32'h0;
   wire        is_fault = vec_fetch_num inside {[EXC_HARD:EXC_USAGE]};
   wire        is_sync  = vec_fetch_num inside {EXC_MEM, EXC_USAGE, EXC_SVC};
   wire        is_async = vec_fetch_num == EXC_NMI || vec_fetch_num >= EXC_PENDABLE_SERVICE_REQUEST;
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   reset_base_a: assert property ($rose(nrst) |-> vector_base_register == VBR_RESET)
      else $error("table base not zero after reset");
   reset_fetch_a: assert property ($rose(nrst) |-> ##[1:2] (vec_fetch_valid && vec_load_sp))
      else $error("stack pointer fetch missing after reset");
   sp_word_a: assert property (vec_fetch_valid && vec_load_sp |->
      vec_fetch_addr == vector_base_register && vec_fetch_num == 6'h00)
      else $error("stack pointer fetch not at table word zero");
   vec_addr_a: assert property (vec_fetch_valid && !vec_load_sp |-> vec_fetch_addr == exp_addr)
      else $error("vector address not base plus four times number");
   active_num_a: assert property (vec_fetch_valid && vec_ack && !vec_load_sp &&
      vec_fetch_num != EXC_RESET |=> active_exception_number_status == $past(vec_fetch_num))
      else $error("active number differs from acknowledged number");
   fault_flag_a: assert property (vec_fetch_valid && !vec_load_sp |-> entry_fault_handler == is_fault)
      else $error("fault handler flag wrong");
   sync_entry_a: assert property (vec_fetch_valid && is_sync |-> entry_sync && !entry_async_slip)
      else $error("synchronous exception flagged asynchronous");
   async_slip_a: assert property (vec_fetch_valid && is_async |-> entry_async_slip && !entry_sync)
      else $error("asynchronous exception without slip flag");
   base_take_a: assert property (vbr_write && vbr_ok |=> vector_base_register == $past(vbr_wdata))
      else $error("legal table base not taken");
   base_keep_a: assert property (vbr_write && !vbr_ok |=> $stable(vector_base_register))
      else $error("illegal table base taken");
   irq_pend_a: assert property (irq_line[0] |=> pending_status[16])
      else $error("interrupt line did not set pending");
endmodule : evt_core_checker

// [evt_dispatch_model.sv]
// Behavioural core fetch logic that accepts vector offers after a set delay
`timescale 1ns/1ps
module evt_dispatch_model (
   input  wire logic       mclk,
   input  wire logic       nrst,
   input  wire logic       vec_fetch_valid,
   input  wire logic [3:0] ack_delay,
   output logic            vec_ack
);
   logic [3:0] wait_cnt;
   // Falling edge drive keeps the ack settled long before the sampling edge
   always_ff @(negedge mclk) begin
      if (!nrst || !vec_fetch_valid || vec_ack) begin
         vec_ack  <= 1'b0;
         wait_cnt <= 4'h0;
      end else if (wait_cnt >= ack_delay) begin
         // Table words come from software with bit zero set, so they are taken as fetched
         vec_ack  <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : evt_dispatch_model

// [exception_type_vector_table_test.sv]
// Self-checking bench for the exception classifier and vector fetch sequencer
`timescale 1ns/1ps
module exception_type_vector_table_test
   import evt_pkg::*;
;
   localparam logic [5:0]  NUMS [15] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h05, 6'h06, 6'h06, 6'h06,
                                        6'h06, 6'h06, 6'h06, 6'h0b, 6'h0e, 6'h0f, 6'h0f};
   localparam logic [14:0] SYNC_MASK = 15'h0fee;
   logic                      mclk, nrst, vbr_write, exc_return, trap_ua, trap_dz;
   logic                      vec_ack, vec_fetch_valid, vec_load_sp, entry_sync, slip, fault;
   logic [14:0]               ev;
   logic [5:0]                en, vec_fetch_num, act;
   logic [3:0]                ack_delay;
   logic [23:0]               psys;
   logic [NUM_IRQ-1:0]        irq_line, irq_sw_req, irq_en;
   logic [NUM_IRQ*PRIO_W-1:0] prio_irq;
   logic [31:0]               vbr_wdata, vec_fetch_addr, vector_base_register, base_exp;
   logic [NUM_EXC-1:0]        pending_status;
   int                        miscompares, check_count;

   evt_core dut (.mclk(mclk), .nrst(nrst), .nmi_req(ev[0]), .entry_error(ev[1]),
      .mem_fault(ev[2]), .bus_err_precise(ev[3]), .bus_err_imprecise(ev[4]),
      .undef_instr(ev[5]), .illegal_unaligned(ev[6]), .invalid_state(ev[7]),
      .return_error(ev[8]), .unaligned_access(ev[9]), .div_by_zero(ev[10]),
      .trap_unaligned_en(trap_ua), .trap_div_zero_en(trap_dz),
      .supervisor_call_instruction(ev[11]), .pendable_service_request(ev[12]),
      .systick_zero(ev[13]), .systick_sw_req(ev[14]), .irq_line(irq_line),
      .irq_sw_req(irq_sw_req), .mem_en(en[0]), .bus_en(en[1]), .usage_en(en[2]),
      .svc_en(en[3]), .pendable_service_request_en(en[4]), .systick_en(en[5]), .irq_en(irq_en),
      .prio_mem(psys[3:0]), .prio_bus(psys[7:4]), .prio_usage(psys[11:8]),
      .prio_svc(psys[15:12]), .prio_pendable_service_request(psys[19:16]), .prio_systick(psys[23:20]),
      .prio_irq(prio_irq), .vbr_write(vbr_write), .vbr_wdata(vbr_wdata),
      .vec_ack(vec_ack), .exc_return(exc_return), .vec_fetch_valid(vec_fetch_valid),
      .vec_fetch_addr(vec_fetch_addr), .vec_fetch_num(vec_fetch_num),
      .vec_load_sp(vec_load_sp), .entry_sync(entry_sync), .entry_async_slip(slip),
      .entry_fault_handler(fault), .active_exception_number_status(act),
      .vector_base_register(vector_base_register), .pending_status(pending_status));
   evt_dispatch_model core (.mclk(mclk), .nrst(nrst), .vec_fetch_valid(vec_fetch_valid),
      .ack_delay(ack_delay), .vec_ack(vec_ack));

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic fire(input logic [14:0] e, input logic [NUM_IRQ-1:0] q, s);
      @(negedge mclk);
      {ev, irq_line, irq_sw_req} = {e, q, s};
      @(negedge mclk);
      {ev, irq_line, irq_sw_req} = '0;
   endtask : fire
   // Waits for an accepted offer, then judges what the core took with it
   task automatic take(input logic [5:0] n, input logic s, input logic fl);
      int k;
      k = 0;
      do begin
         @(negedge mclk);
         #2;
         k++;
      end while (!(vec_fetch_valid === 1'b1 && vec_ack === 1'b1) && k < 40);
      if (k >= 40) begin
         chk("offer wait", 32'h1, 32'h0);
         results();
      end
      chk("number", {26'h0, n}, {26'h0, vec_fetch_num});
      chk("address", base_exp + {24'h0, n, 2'b00}, vec_fetch_addr);
      chk("load sp", {31'h0, n == 6'h00}, {31'h0, vec_load_sp});
      if (fl) chk("flags", {29'h0, s, ~s, n >= 6'h03 && n <= 6'h06}, {29'h0, entry_sync, slip, fault});
      @(negedge mclk);
      chk("active", {26'h0, n == 6'h01 ? 6'h00 : n}, {26'h0, act});
   endtask : take
   task automatic ret();
      @(negedge mclk);
      exc_return = 1'b1;
      @(negedge mclk);
      exc_return = 1'b0;
      chk("active after return", 32'h0, {26'h0, act});
   endtask : ret
   task automatic idle(input int bit_no);
      repeat (10) @(negedge mclk);
      chk("quiet offer", 32'h0, {31'h0, vec_fetch_valid});
      if (bit_no > 0) chk("held pending", 32'h1, {31'h0, pending_status[bit_no]});
   endtask : idle
   task automatic t_types();
      for (int i = 0; i < 15; i++) begin
         ack_delay = {2'h0, i[1:0]};
         fire(15'h1 << i, '0, '0);
         take(NUMS[i], SYNC_MASK[i], 1'b1);
         ret();
      end
   endtask : t_types
   task automatic t_prio();
      prio_irq[11:4] = 8'h52;
      prio_irq[19:12] = 8'h77;
      fire('0, 33'h6, '0);
      take(6'h11, 1'b0, 1'b1);
      ret();
      take(6'h12, 1'b0, 1'b1);
      ret();
      fire('0, 33'h18, '0);
      take(6'h13, 1'b0, 1'b1);
      ret();
      take(6'h14, 1'b0, 1'b1);
      ret();
      fire(15'h3, 33'h1, '0);
      take(6'h02, 1'b0, 1'b1);
      ret();
      take(6'h03, 1'b1, 1'b1);
      ret();
      take(6'h10, 1'b0, 1'b1);
      ret();
      psys[23:20] = 4'h1;
      fire(15'h4000, 33'h1, '0);
      take(6'h10, 1'b0, 1'b1);
      ret();
      take(6'h0f, 1'b0, 1'b1);
      ret();
   endtask : t_prio
   task automatic t_mask();
      en[2] = 1'b0;
      fire(15'h20, '0, '0);
      take(6'h03, 1'b1, 1'b1);
      ret();
      irq_en[5] = 1'b0;
      fire('0, 33'h20, '0);
      idle(21);
      irq_en[5] = 1'b1;
      take(6'h15, 1'b0, 1'b1);
      ret();
      fire('0, '0, 33'h1_0000_0000);
      take(6'h30, 1'b0, 1'b1);
      ret();
      en[3] = 1'b0;
      fire(15'h800, '0, '0);
      take(6'h03, 1'b1, 1'b1);
      ret();
      en[3] = 1'b1;
      en[4] = 1'b0;
      fire(15'h1000, '0, '0);
      idle(14);
      en[4] = 1'b1;
      take(6'h0e, 1'b0, 1'b1);
      ret();
      {trap_ua, trap_dz} = 2'b00;
      fire(15'h600, '0, '0);
      idle(0);
   endtask : t_mask
   task automatic t_vbr();
      @(negedge mclk);
      {vbr_write, vbr_wdata} = {1'b1, 32'h0000_0040};
      @(negedge mclk);
      chk("base kept", 32'h0, vector_base_register);
      vbr_wdata = 32'h0000_0100;
      @(negedge mclk);
      vbr_write = 1'b0;
      chk("base moved", 32'h0000_0100, vector_base_register);
      base_exp = 32'h0000_0100;
      fire('0, 33'h1, '0);
      take(6'h10, 1'b0, 1'b1);
      ret();
   endtask : t_vbr
   // Mid-run reset must drop a moved table base back to zero
   task automatic t_rst();
      @(negedge mclk);
      nrst = 1'b0;
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      base_exp = 32'h0;
      chk("base after reset", 32'h0, vector_base_register);
      chk("pending after reset", 32'h0, {31'h0, |pending_status});
      take(6'h00, 1'b0, 1'b0);
      take(6'h01, 1'b0, 1'b0);
   endtask : t_rst

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   initial begin
      {nrst, vbr_write, exc_return, ev, irq_line, irq_sw_req, vbr_wdata} = '0;
      {trap_ua, trap_dz, en, irq_en, psys, prio_irq, ack_delay, base_exp} = '1;
      {psys, prio_irq, ack_delay, base_exp} = '0;
      repeat (20) @(negedge mclk);
      nrst = 1'b1;
      take(6'h00, 1'b0, 1'b0);
      take(6'h01, 1'b0, 1'b0);
      t_types();
      t_prio();
      t_mask();
      t_vbr();
      t_rst();
      results();
   end
endmodule : exception_type_vector_table_test

bind evt_core evt_core_checker chk_i (.*);
